//--- design/dpfifo_top.sv
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
// Operation
// - Input direction, threshold clear: bus status while at least one byte free.
// - Input direction, threshold set: bus status while at least two bytes free.
// - Input direction: block status exactly when FIFO empty.
// - Output direction, threshold clear: bus status while at least one byte held.
// - Output direction, threshold set: bus status while at least two bytes held.
// - Output direction: block status exactly when FIFO full.
// - Bus status is an output pin usable as interrupt or DMA request.
// - Simultaneous read and write keeps occupancy and status correct.
// - Output direction with fast mode samples load control every bus clock.
// - Level mode writes accumulator every sampling cycle load control is high.
// - Edge mode captures once per rising edge of load control.
// - One edge-mode bit serves both FIFOs; edge sampled on selected clock.
// - One capture bit serves both FIFOs, effective only in output direction.
// - With capture enabled, bus read of accumulator writes it into its FIFO.
// - Capture trigger passes through chain input and output across blocks.
// - Load control ORed with software capture; either triggers a capture.
// - Writing one to flush bit resets FIFO; zero resumes operation.
// - Flush held set: single-byte register, no status, direction still applies.
// - Each FIFO holds four bytes with its own threshold bit.
// - Direction 00 bus input, 01 accumulator zero, 10 accumulator one, 11 ALU.
// - No overflow or underflow protection; pointers stay accurate.
module dpfifo_top #(
    parameter int DEPTH = dpfifo_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dpfifo_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [dpfifo_pkg::APB_DATA_W-1:0] pwdata,
    output logic [dpfifo_pkg::APB_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dp_clk_in,
    input wire logic [dpfifo_pkg::DATA_W-1:0] accumulator_zero,
    input wire logic [dpfifo_pkg::DATA_W-1:0] accumulator_one,
    input wire logic [dpfifo_pkg::DATA_W-1:0] alu_result,
    input wire logic fifo0_load_strobe,
    input wire logic fifo1_load_strobe,
    input wire logic fifo0_dp_read,
    input wire logic fifo1_dp_read,
    output logic [dpfifo_pkg::DATA_W-1:0] fifo_zero_dout,
    output logic [dpfifo_pkg::DATA_W-1:0] fifo_one_dout,
    output logic fifo0_bus_stat,
    output logic fifo0_blk_stat,
    output logic fifo1_bus_stat,
    output logic fifo1_blk_stat,
    input wire logic [1:0] capture_chain_in,
    output logic [1:0] capture_chain_out
);
    import dpfifo_pkg::*;

    logic rst_meta_reg;
    logic rst_n_sync;
    logic [CFG_W-1:0] config_reg;
    logic [AUX_W-1:0] aux_control_reg;
    logic dp_clk_meta_reg;
    logic dp_clk_sync_reg;
    logic dp_clk_prev_reg;
    logic dp_tick;
    logic apb_rd_fire;
    logic apb_wr_fire;
    logic addr_mapped;
    logic [APB_DATA_W-1:0] prdata_next;
    logic [1:0] local_capture;
    logic [1:0] fifo_direction_select [2];
    logic [1:0] fast_mode;
    logic [1:0] fifo_flush;
    logic [1:0] fifo_status_threshold;
    logic [1:0] load_strobe;
    logic [1:0] dp_read;
    logic [1:0] bus_push;
    logic [1:0] bus_pop;
    logic [1:0] bus_stat;
    logic [1:0] blk_stat;
    logic [DATA_W-1:0] head_data [2];
    logic [CNT_W-1:0] occupancy [2];

    // Status decode shared by both FIFOs; flush disables status altogether
    function automatic logic [1:0] fifo_status(input logic [1:0] dir, input logic thr,
                                               input logic [CNT_W-1:0] cnt, input logic flush);
        logic [CNT_W-1:0] free_cnt;
        logic [CNT_W-1:0] need;
        logic [1:0] st;
        free_cnt = CNT_W'(DEPTH) - cnt;
        need = thr ? THR_HIGH : THR_LOW;
        if (dir == DIR_INPUT) begin
            st[0] = (free_cnt >= need);
            st[1] = (cnt == '0);
        end else begin
            st[0] = (cnt >= need);
            st[1] = (cnt == CNT_W'(DEPTH));
        end
        if (flush) begin
            st = 2'b00;
        end
        return st;
    endfunction : fifo_status

    // Reset release through two flops
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_sync <= rst_meta_reg;
        end
    end

    // Datapath clock arrives as a slower level; its rising edge becomes a one-cycle tick
    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            dp_clk_meta_reg <= 1'b0;
            dp_clk_sync_reg <= 1'b0;
            dp_clk_prev_reg <= 1'b0;
        end else begin
            dp_clk_meta_reg <= dp_clk_in;
            dp_clk_sync_reg <= dp_clk_meta_reg;
            dp_clk_prev_reg <= dp_clk_sync_reg;
        end
    end
    assign dp_tick = dp_clk_sync_reg & ~dp_clk_prev_reg;

    // APB slave: zero wait states
    assign pready = 1'b1;
    assign apb_rd_fire = psel & penable & ~pwrite;
    assign apb_wr_fire = psel & penable & pwrite;
    always_comb begin
        case (paddr)
            CONFIG_OFFSET, AUX_CTRL_OFFSET, ACC0_OFFSET, ACC1_OFFSET,
            FIFO0_DATA_OFFSET, FIFO1_DATA_OFFSET, STATUS_OFFSET: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~addr_mapped;

    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            config_reg <= CFG_RESET;
        end else if (apb_wr_fire && paddr == CONFIG_OFFSET) begin
            config_reg <= pwdata[CFG_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            aux_control_reg <= AUX_RESET;
        end else if (apb_wr_fire && paddr == AUX_CTRL_OFFSET) begin
            aux_control_reg <= pwdata[AUX_W-1:0];
        end
    end

    assign fifo_direction_select[0] = config_reg[CFG_DIR0_LSB +: 2];
    assign fifo_direction_select[1] = config_reg[CFG_DIR1_LSB +: 2];
    assign fast_mode = {config_reg[CFG_FAST1_BIT], config_reg[CFG_FAST0_BIT]};
    assign fifo_flush = {aux_control_reg[AUX_FLUSH1_BIT], aux_control_reg[AUX_FLUSH0_BIT]};
    assign fifo_status_threshold = {aux_control_reg[AUX_THR1_BIT], aux_control_reg[AUX_THR0_BIT]};
    assign load_strobe = {fifo1_load_strobe, fifo0_load_strobe};
    assign dp_read = {fifo1_dp_read, fifo0_dp_read};

    // Accumulator reads raise the capture trigger; chain passes it on unchanged
    assign local_capture[0] = apb_rd_fire & (paddr == ACC0_OFFSET) & config_reg[CFG_CAPTURE_BIT];
    assign local_capture[1] = apb_rd_fire & (paddr == ACC1_OFFSET) & config_reg[CFG_CAPTURE_BIT];
    assign capture_chain_out = local_capture | capture_chain_in;

    assign bus_push[0] = apb_wr_fire & (paddr == FIFO0_DATA_OFFSET) & (fifo_direction_select[0] == DIR_INPUT);
    assign bus_push[1] = apb_wr_fire & (paddr == FIFO1_DATA_OFFSET) & (fifo_direction_select[1] == DIR_INPUT);
    assign bus_pop[0] = apb_rd_fire & (paddr == FIFO0_DATA_OFFSET) & (fifo_direction_select[0] != DIR_INPUT);
    assign bus_pop[1] = apb_rd_fire & (paddr == FIFO1_DATA_OFFSET) & (fifo_direction_select[1] != DIR_INPUT);

    for (genvar i = 0; i < 2; i++) begin : g_fifo
        logic [DATA_W-1:0] mem [DEPTH];
        logic [PTR_W-1:0] wr_ptr_reg;
        logic [PTR_W-1:0] rd_ptr_reg;
        logic [CNT_W-1:0] count_reg;
        logic [CNT_W-1:0] count_next;
        logic load_prev_reg;
        logic is_output;
        logic sample_tick;
        logic hw_write;
        logic sw_capture;
        logic push;
        logic pop;
        logic [DATA_W-1:0] push_data;
        logic [PTR_W-1:0] wr_index;
        logic [PTR_W-1:0] rd_index;

        assign is_output = (fifo_direction_select[i] != DIR_INPUT);
        // Fast mode trades power for bus-clock capture resolution
        assign sample_tick = (is_output && fast_mode[i]) ? 1'b1 : dp_tick;

        // Edge history advances only on the selected FIFO clock
        always_ff @(posedge core_clk or negedge rst_n_sync) begin
            if (!rst_n_sync) begin
                load_prev_reg <= 1'b0;
            end else if (sample_tick) begin
                load_prev_reg <= load_strobe[i];
            end
        end

        always_comb begin
            if (config_reg[CFG_EDGE_BIT]) begin
                hw_write = sample_tick & load_strobe[i] & ~load_prev_reg;
            end else begin
                hw_write = sample_tick & load_strobe[i];
            end
        end

        assign sw_capture = capture_chain_out[i] & config_reg[CFG_CAPTURE_BIT] & is_output;

        always_comb begin
            case (fifo_direction_select[i])
                DIR_OUT_ACC0: push_data = accumulator_zero;
                DIR_OUT_ACC1: push_data = accumulator_one;
                DIR_OUT_ALU: push_data = alu_result;
                default: push_data = pwdata[DATA_W-1:0];
            endcase
        end

        assign push = is_output ? (hw_write | sw_capture) : bus_push[i];
        assign pop = is_output ? bus_pop[i] : (dp_tick & dp_read[i]);

        // Flush holds the FIFO as one slot at index zero
        assign wr_index = fifo_flush[i] ? '0 : wr_ptr_reg;
        assign rd_index = fifo_flush[i] ? '0 : rd_ptr_reg;

        always_ff @(posedge core_clk) begin
            if (push) begin
                mem[wr_index] <= push_data;
            end
        end

        // Overflow writes the front slot; underflow leaves pointers alone
        always_comb begin
            count_next = count_reg;
            if (push && !pop && count_reg != CNT_W'(DEPTH)) begin
                count_next = count_reg + CNT_W'(1);
            end else if (pop && !push && count_reg != '0) begin
                count_next = count_reg - CNT_W'(1);
            end else if (pop && push && count_reg == '0) begin
                count_next = CNT_W'(1);
            end
        end

        always_ff @(posedge core_clk or negedge rst_n_sync) begin
            if (!rst_n_sync) begin
                wr_ptr_reg <= '0;
                rd_ptr_reg <= '0;
                count_reg <= '0;
            end else if (fifo_flush[i]) begin
                wr_ptr_reg <= '0;
                rd_ptr_reg <= '0;
                count_reg <= '0;
            end else begin
                if (push) begin
                    wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
                end
                if ((pop && count_reg != '0) || (push && !pop && count_reg == CNT_W'(DEPTH))) begin
                    rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
                end
                count_reg <= count_next;
            end
        end

        assign head_data[i] = mem[rd_index];
        assign occupancy[i] = count_reg;
        assign {blk_stat[i], bus_stat[i]} = fifo_status(fifo_direction_select[i],
                                                       fifo_status_threshold[i], count_reg, fifo_flush[i]);
    end

    // Head bytes to the datapath come from flops
    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            fifo_zero_dout <= '0;
            fifo_one_dout <= '0;
        end else begin
            fifo_zero_dout <= head_data[0];
            fifo_one_dout <= head_data[1];
        end
    end

    assign fifo0_bus_stat = bus_stat[0];
    assign fifo0_blk_stat = blk_stat[0];
    assign fifo1_bus_stat = bus_stat[1];
    assign fifo1_blk_stat = blk_stat[1];

    // Read data latched in the setup phase, so it is stable through the access phase
    always_comb begin
        prdata_next = '0;
        case (paddr)
            CONFIG_OFFSET: prdata_next[CFG_W-1:0] = config_reg;
            AUX_CTRL_OFFSET: prdata_next[AUX_W-1:0] = aux_control_reg;
            ACC0_OFFSET: prdata_next[DATA_W-1:0] = accumulator_zero;
            ACC1_OFFSET: prdata_next[DATA_W-1:0] = accumulator_one;
            FIFO0_DATA_OFFSET: prdata_next[DATA_W-1:0] = head_data[0];
            FIFO1_DATA_OFFSET: prdata_next[DATA_W-1:0] = head_data[1];
            STATUS_OFFSET: begin
                prdata_next[STAT_BUS0_BIT] = bus_stat[0];
                prdata_next[STAT_BLK0_BIT] = blk_stat[0];
                prdata_next[STAT_BUS1_BIT] = bus_stat[1];
                prdata_next[STAT_BLK1_BIT] = blk_stat[1];
                prdata_next[STAT_CNT0_LSB +: CNT_W] = occupancy[0];
                prdata_next[STAT_CNT1_LSB +: CNT_W] = occupancy[1];
            end
            default: prdata_next = '0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= prdata_next;
        end
    end

endmodule : dpfifo_top

//--- common/dpfifo_pkg.sv
package dpfifo_pkg;

    // Datapath word and FIFO shape
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int PTR_W = 2;
    localparam int CNT_W = 3;
    localparam int APB_ADDR_W = 8;
    localparam int APB_DATA_W = 32;

    // Register byte offsets
    localparam logic [APB_ADDR_W-1:0] CONFIG_OFFSET = 8'h00;
    localparam logic [APB_ADDR_W-1:0] AUX_CTRL_OFFSET = 8'h04;
    localparam logic [APB_ADDR_W-1:0] ACC0_OFFSET = 8'h08;
    localparam logic [APB_ADDR_W-1:0] ACC1_OFFSET = 8'h0C;
    localparam logic [APB_ADDR_W-1:0] FIFO0_DATA_OFFSET = 8'h10;
    localparam logic [APB_ADDR_W-1:0] FIFO1_DATA_OFFSET = 8'h14;
    localparam logic [APB_ADDR_W-1:0] STATUS_OFFSET = 8'h18;

    // Configuration register fields
    localparam int CFG_DIR0_LSB = 0;
    localparam int CFG_DIR1_LSB = 2;
    localparam int CFG_EDGE_BIT = 4;
    localparam int CFG_CAPTURE_BIT = 5;
    localparam int CFG_FAST0_BIT = 6;
    localparam int CFG_FAST1_BIT = 7;
    localparam int CFG_W = 8;
    localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

    // Auxiliary control register fields
    localparam int AUX_FLUSH0_BIT = 0;
    localparam int AUX_FLUSH1_BIT = 1;
    localparam int AUX_THR0_BIT = 2;
    localparam int AUX_THR1_BIT = 3;
    localparam int AUX_W = 4;
    localparam logic [AUX_W-1:0] AUX_RESET = 4'h0;

    // Status register fields
    localparam int STAT_BUS0_BIT = 0;
    localparam int STAT_BLK0_BIT = 1;
    localparam int STAT_BUS1_BIT = 2;
    localparam int STAT_BLK1_BIT = 3;
    localparam int STAT_CNT0_LSB = 4;
    localparam int STAT_CNT1_LSB = 8;

    // Direction select encodings
    localparam logic [1:0] DIR_INPUT = 2'h0;
    localparam logic [1:0] DIR_OUT_ACC0 = 2'h1;
    localparam logic [1:0] DIR_OUT_ACC1 = 2'h2;
    localparam logic [1:0] DIR_OUT_ALU = 2'h3;

    // Status thresholds
    localparam logic [CNT_W-1:0] THR_LOW = 3'h1;
    localparam logic [CNT_W-1:0] THR_HIGH = 3'h2;

endpackage : dpfifo_pkg

//--- sim/dpfifo_checker.sv
`timescale 1ns/1ps
module dpfifo_checker import dpfifo_pkg::*; (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dpfifo_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [dpfifo_pkg::APB_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic fifo0_bus_stat,
    input wire logic fifo0_blk_stat,
    input wire logic fifo1_bus_stat,
    input wire logic fifo1_blk_stat,
    input wire logic [1:0] capture_chain_in,
    input wire logic [1:0] capture_chain_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence acc_rd;
        psel && penable && !pwrite;
    endsequence
    // Empty (input) and full (output) both sit inside the bus threshold
    blk_bus0_a: assert property (fifo0_blk_stat |-> fifo0_bus_stat)
        else $error("fifo0 block without bus");
    blk_bus1_a: assert property (fifo1_blk_stat |-> fifo1_bus_stat)
        else $error("fifo1 block without bus");
    chain_pass0_a: assert property (capture_chain_in[0] |-> capture_chain_out[0])
        else $error("chain 0 lost");
    chain_pass1_a: assert property (capture_chain_in[1] |-> capture_chain_out[1])
        else $error("chain 1 lost");
    // A chain pulse must come from a neighbour or from a local accumulator read
    chain_src0_a: assert property (capture_chain_out[0] |-> capture_chain_in[0]
        || (psel && penable && !pwrite && paddr == ACC0_OFFSET)) else $error("chain 0 without trigger");
    chain_src1_a: assert property (capture_chain_out[1] |-> capture_chain_in[1]
        || (psel && penable && !pwrite && paddr == ACC1_OFFSET)) else $error("chain 1 without trigger");
    reset_empty_a: assert property ($rose(rstn) |->
        fifo0_blk_stat && fifo0_bus_stat && fifo1_blk_stat && fifo1_bus_stat) else $error("not empty after reset");
    err_unmapped_a: assert property (acc_rd ##0 paddr > STATUS_OFFSET |-> pslverr && prdata == '0)
        else $error("unmapped read not refused");
    ok_mapped_a: assert property (psel && penable && paddr <= STATUS_OFFSET && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    rdata_hold_a: assert property (acc_rd |=> $stable(prdata)) else $error("read data moved");
endmodule : dpfifo_checker

bind dpfifo_top dpfifo_checker i_chk (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .pslverr, .fifo0_bus_stat, .fifo0_blk_stat, .fifo1_bus_stat, .fifo1_blk_stat, .capture_chain_in,
    .capture_chain_out);

//--- sim/dpfifo_apb_host.sv
`timescale 1ns/1ps
module dpfifo_apb_host import dpfifo_pkg::*; (
    input wire logic core_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [dpfifo_pkg::APB_ADDR_W-1:0] paddr,
    output logic [dpfifo_pkg::APB_DATA_W-1:0] pwdata,
    input wire logic [dpfifo_pkg::APB_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic [APB_DATA_W-1:0] rdata;
    logic err;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end
    // Accumulator read data is kept but callers ignore it; value comes from the FIFO
    task automatic xfer(input logic wr, input logic [APB_ADDR_W-1:0] a, input logic [APB_DATA_W-1:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (!pready) @(posedge core_clk);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next setup never lands in the release time step
        @(posedge core_clk);
    endtask : xfer
endmodule : dpfifo_apb_host

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    import dpfifo_pkg::*;
    logic core_clk, rstn, psel, penable, pwrite, pready, pslverr, dp_clk_in, ld0, ld1, dprd0, dprd1;
    logic bus0, blk0, bus1, blk1;
    logic [APB_ADDR_W-1:0] paddr;
    logic [APB_DATA_W-1:0] pwdata, prdata;
    logic [DATA_W-1:0] acc0, acc1, alu, dout0, dout1;
    logic [1:0] ch_in, ch_out;
    logic [7:0] cfg, q0[$], q1[$];
    logic [3:0] aux;
    int n_fail, n_compared, seed;
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    dpfifo_top i_dut (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .dp_clk_in, .accumulator_zero(acc0), .accumulator_one(acc1), .alu_result(alu), .fifo0_load_strobe(ld0),
        .fifo1_load_strobe(ld1), .fifo0_dp_read(dprd0), .fifo1_dp_read(dprd1), .fifo_zero_dout(dout0),
        .fifo_one_dout(dout1), .fifo0_bus_stat(bus0), .fifo0_blk_stat(blk0), .fifo1_bus_stat(bus1),
        .fifo1_blk_stat(blk1), .capture_chain_in(ch_in), .capture_chain_out(ch_out));
    dpfifo_apb_host i_host (.core_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    function automatic logic [31:0] exp_stat();
        logic [31:0] s;
        int n;
        s = '0;
        for (int i = 0; i < 2; i++) begin
            n = i ? q1.size() : q0.size();
            if (!aux[i]) begin
                s[2*i] = cfg[2*i +: 2] == DIR_INPUT ? 4 - n >= (aux[2+i] ? 2 : 1) : n >= (aux[2+i] ? 2 : 1);
                s[2*i+1] = cfg[2*i +: 2] == DIR_INPUT ? n == 0 : n == FIFO_DEPTH;
                s[4+4*i +: 3] = 3'(n);
            end
        end
        return s;
    endfunction : exp_stat
    task automatic push(ref logic [7:0] q[$], input logic [7:0] d);
        if (q.size() == FIFO_DEPTH) void'(q.pop_front());
        q.push_back(d);
    endtask : push
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    task automatic stat();
        logic [31:0] e;
        i_host.xfer(1'b0, STATUS_OFFSET, '0);
        e = exp_stat();
        chk("status", i_host.rdata, e);
        chk("status pins", {28'h000_0000, blk1, bus1, blk0, bus0}, {28'h000_0000, e[3:0]});
    endtask : stat
    task automatic rdf(input logic [7:0] a, input logic [7:0] e);
        i_host.xfer(1'b0, a, '0);
        chk("fifo data", i_host.rdata, {24'h00_0000, e});
    endtask : rdf
    task automatic setc(input logic [7:0] c);
        cfg = c;
        i_host.xfer(1'b1, CONFIG_OFFSET, {24'h00_0000, c});
    endtask : setc
    task automatic seta(input logic [3:0] a);
        aux = a;
        if (a[0]) q0.delete();
        if (a[1]) q1.delete();
        i_host.xfer(1'b1, AUX_CTRL_OFFSET, {28'h000_0000, a});
    endtask : seta
    task automatic ldpulse(input int len);
        ld0 <= 1'b1;
        cyc(len);
        ld0 <= 1'b0;
        cyc(2);
    endtask : ldpulse
    task automatic dptick();
        dp_clk_in <= 1'b1;
        cyc(4);
        dp_clk_in <= 1'b0;
        cyc(4);
    endtask : dptick
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        print_verdict();
    end
    initial begin
        logic [7:0] d;
        seed = 33;
        {n_fail, n_compared} = '0;
        {rstn, dp_clk_in, ld0, ld1, dprd0, dprd1, ch_in, cfg, aux, acc0, acc1, alu} = '0;
        cyc(20);
        rstn <= 1'b1;
        cyc(3);
        stat();
        seta(4'h4);
        for (int k = 0; k < 5; k++) begin
            d = 8'($random(seed));
            i_host.xfer(1'b1, FIFO0_DATA_OFFSET, {24'h00_0000, d});
            push(q0, d);
            stat();
        end
        seta(4'h0);
        stat();
        rdf(FIFO0_DATA_OFFSET, q0[0]);
        dprd0 <= 1'b1;
        dptick();
        dprd0 <= 1'b0;
        void'(q0.pop_front());
        chk("dout0", {24'h00_0000, dout0}, {24'h00_0000, q0[0]});
        stat();
        $display("test done: input direction");
        seta(4'h1);
        i_host.xfer(1'b1, FIFO0_DATA_OFFSET, 32'h0000_00A5);
        i_host.xfer(1'b1, FIFO0_DATA_OFFSET, 32'h0000_005A);
        rdf(FIFO0_DATA_OFFSET, 8'h5A);
        stat();
        seta(4'h0);
        stat();
        $display("test done: flush");
        setc(8'h51);
        for (int k = 0; k < 5; k++) begin
            acc0 <= 8'($random(seed));
            ldpulse(3);
            push(q0, acc0);
            stat();
        end
        seta(4'h4);
        for (int k = 0; k < 4; k++) begin
            rdf(FIFO0_DATA_OFFSET, q0.pop_front());
            stat();
        end
        setc(8'h01);
        ld0 <= 1'b1;
        stat();
        dptick();
        ld0 <= 1'b0;
        push(q0, acc0);
        stat();
        // Edge mode on the datapath tick: one low tick, then a strobe held over two ticks loads once
        setc(8'h11);
        dptick();
        ld0 <= 1'b1;
        dptick();
        dptick();
        ld0 <= 1'b0;
        push(q0, acc0);
        stat();
        $display("test done: datapath load");
        seta(4'h1);
        seta(4'h0);
        setc(8'h21);
        acc0 <= 8'($random(seed));
        acc1 <= 8'($random(seed));
        i_host.xfer(1'b0, ACC1_OFFSET, '0);
        stat();
        i_host.xfer(1'b0, ACC0_OFFSET, '0);
        rdf(FIFO0_DATA_OFFSET, acc0);
        setc(8'h29);
        ch_in <= 2'b10;
        cyc(1);
        ch_in <= 2'b00;
        push(q1, acc1);
        stat();
        chk("dout1", {24'h00_0000, dout1}, {24'h00_0000, q1[0]});
        setc(8'hA9);
        ld1 <= 1'b1;
        rdf(FIFO1_DATA_OFFSET, q1[0]);
        ld1 <= 1'b0;
        void'(q1.pop_front());
        repeat (3) push(q1, acc1);
        stat();
        $display("test done: capture");
        setc(8'h43);
        seta(4'h8);
        alu <= 8'($random(seed));
        ldpulse(2);
        repeat (2) push(q0, alu);
        stat();
        rdf(FIFO0_DATA_OFFSET, alu);
        void'(q0.pop_front());
        i_host.xfer(1'b1, 8'h40, 32'h0000_00FF);
        chk("unmapped error", {31'h0000_0000, i_host.err}, 32'h0000_0001);
        i_host.xfer(1'b0, 8'h40, '0);
        chk("unmapped data", i_host.rdata, 32'h0000_0000);
        stat();
        $display("test done: alu and refusals");
        print_verdict();
    end
endmodule : testbench
